// File: hw/ptcc_ctrl.sv
// status, flags, enables and per-circuit compare/capture control of one timer channel
//
// Functional notes
// - status bits 7..2 return live levels of capture pins 5..0
// - status bits of absent capture pins read zero
// - direction bit reads 1 when counting up, resets to 1
// - running bit reads 1 while counting, resets to 0
// - flag word: overwrite/compare pairs 13..2, MAX bit 1, zero bit 0
// - writing 1 clears a flag, writing 0 leaves it
// - enable word mirrors flag layout, read/write, resets to 0
// - flags and enables of absent circuits stay zero
// - sync capture select chooses sync or async capture, capture mode only
// - timing 0: buffer loads on the edge after a data write
// - timing 1: load at MAX up, zero down, either up/down
// - timing 2: load on match with buffered value
// - timing 3: load at wrap, up/down on match or zero
// - timing 4: load on match and reset the counter
// - load timing acts in compare mode, trigger fields in capture mode
// - trigger source: pin, software low, software high
// - pin edge select: both, falling, rising, or disabled
// - software edges are source changes 2 to 3 and 3 to 2
// - paired mode uses both pair matches, else own match and MAX/ZERO
// - software output level drives output in generation mode 0
// - interrupt request only when a flag and its enable are set
// - overwrite flag sets when capture hits with compare flag still set
// - circuit mode bit: 1 capture register, 0 compare register
// - software level 1 drives high, 0 drives low, while output invert is clear
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps

module ptcc_ctrl
  import ptcc_pkg::*;
#(
  parameter int NCC = CC_MAX
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  // counter core
  input  wire ptcc_cnt_t         cnt,
  output logic                   counterResetReq,
  output logic                   counterResetToMax,
  // pins
  input  wire logic [CC_MAX-1:0] captureInputPin,
  output logic      [CC_MAX-1:0] waveformOutput,
  // interrupt request
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  localparam logic [CC_MAX-1:0] PRESENT = CC_MAX'((1 << NCC) - 1);

  function automatic logic [15:0] flagMask(input int n);
    logic [15:0] m;
    m = 16'h0003;
    for (int i = 0; i < CC_MAX; i++) begin
      if (i < n) begin
        m[FLAG_CC_LSB + 2 * i]     = 1'b1;
        m[FLAG_CC_LSB + 2 * i + 1] = 1'b1;
      end
    end
    return m;
  endfunction : flagMask

  localparam logic [15:0] FLAG_MASK = flagMask(NCC);

  function automatic logic [3:0] slot(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    if (a >= base && d[1:0] == 2'h0 && d[7:2] < 6'(CC_MAX)) begin
      return 4'(d[7:2]);
    end
    return SLOT_NONE;
  endfunction : slot

  function automatic logic loadCond(input logic [2:0] t, input logic [1:0] md,
                                    input logic mt, input logic mx, input logic zr);
    case (t)
      LOAD_END:   return (md == CNT_UP) ? mx : (md == CNT_DOWN) ? zr : (mx | zr);
      LOAD_MATCH: return mt;
      LOAD_WRAP:  return (md == CNT_UP) ? zr : (md == CNT_DOWN) ? mx : (mt | zr);
      LOAD_MRST:  return mt;
      default:    return 1'b0;
    endcase
  endfunction : loadCond

  ////////////////////////////////////////////////////////////////////////////
  // storage

  ptcc_ctl_t         ctl_reg   [CC_MAX];
  logic [15:0]       data_reg  [CC_MAX];
  logic [15:0]       buf_reg   [CC_MAX];
  logic [15:0]       flags_reg;
  logic [15:0]       enables_reg;
  logic              dir_reg;
  logic              run_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              rstReq_reg;
  logic              rstMax_reg;
  logic [CC_MAX-1:0] matchPrev_reg;
  logic [CC_MAX-1:0] pinPrev_reg;
  logic [CC_MAX-1:0] trigDly_reg;
  logic [CC_MAX-1:0] pend_reg;
  logic [CC_MAX-1:0] level_reg;
  logic [CC_MAX-1:0] match;
  logic [CC_MAX-1:0] matchPulse;
  logic [CC_MAX-1:0] capEvt;
  logic [CC_MAX-1:0] mrst;
  logic [CC_MAX-1:0] outInv;
  logic [15:0]       flagSet;
  logic [15:0]       flagClr;
  logic [15:0]       flags_next;
  logic [3:0]        ctlSlot;
  logic [3:0]        dataSlot;
  ptcc_ctl_t         wctl;

  assign ctlSlot  = slot(regAddr, OFF_CTL_BASE);
  assign dataSlot = slot(regAddr, OFF_DATA_BASE);
  assign wctl     = ptcc_ctl_t'(regWdata);

  ////////////////////////////////////////////////////////////////////////////
  // per-circuit compare, capture and output

  for (genvar g = 0; g < CC_MAX; g++) begin : gCc
    localparam int P = g ^ 1;
    logic ctlWr;
    logic dataWr;
    logic isCap;
    logic swRise;
    logic swFall;
    logic pinRise;
    logic pinFall;
    logic trigRaw;
    logic evtA;
    logic evtB;
    logic pairedOnly;

    assign ctlWr   = regWr && ctlSlot == 4'(g) && PRESENT[g];
    assign dataWr  = regWr && dataSlot == 4'(g) && PRESENT[g];
    assign isCap   = ctl_reg[g].circuitModeSelect;
    assign match[g]      = !isCap && cnt.value == buf_reg[g];
    assign matchPulse[g] = match[g] && !matchPrev_reg[g];
    assign mrst[g] = matchPulse[g] && ctl_reg[g].bufferLoadTiming == LOAD_MRST;

    // software trigger edges from source field rewrites
    assign swRise = ctlWr && ctl_reg[g].captureTriggerSource == SRC_SWLO
                 && wctl.captureTriggerSource == SRC_SWHI;
    assign swFall = ctlWr && ctl_reg[g].captureTriggerSource == SRC_SWHI
                 && wctl.captureTriggerSource == SRC_SWLO;
    assign pinRise = captureInputPin[g] && !pinPrev_reg[g];
    assign pinFall = !captureInputPin[g] && pinPrev_reg[g];

    always_comb begin
      trigRaw = 1'b0;
      if (isCap) begin
        if (ctl_reg[g].captureTriggerSource == SRC_PIN) begin
          trigRaw = (pinRise && ctl_reg[g].captureTriggerEdge[0])
                 || (pinFall && ctl_reg[g].captureTriggerEdge[1]);
        end else begin
          trigRaw = (swRise && ctl_reg[g].captureTriggerEdge[0])
                 || (swFall && ctl_reg[g].captureTriggerEdge[1]);
        end
      end
    end

    assign capEvt[g] = PRESENT[g] && (ctl_reg[g].syncCaptureSelect ? trigDly_reg[g] : trigRaw);

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        // counter and buffer both sit at zero after reset: no match event then
        matchPrev_reg[g] <= 1'b1;
        pinPrev_reg[g]   <= 1'b0;
        trigDly_reg[g]   <= 1'b0;
      end else begin
        matchPrev_reg[g] <= match[g];
        pinPrev_reg[g]   <= captureInputPin[g];
        trigDly_reg[g]   <= trigRaw;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ctl_reg[g] <= '0;
      end else if (ctlWr) begin
        ctl_reg[g]          <= wctl;
        ctl_reg[g].reserved <= 1'b0;
      end
    end

    // data register: captures win over a software write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        data_reg[g] <= CNT_ZERO;
      end else if (capEvt[g]) begin
        data_reg[g] <= cnt.value;
      end else if (dataWr) begin
        data_reg[g] <= regWdata;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pend_reg[g] <= 1'b0;
        buf_reg[g]  <= CNT_ZERO;
      end else begin
        pend_reg[g] <= dataWr && !isCap && ctl_reg[g].bufferLoadTiming == LOAD_IMMED;
        if (isCap) begin
          buf_reg[g] <= buf_reg[g];
        end else if (pend_reg[g]) begin
          buf_reg[g] <= data_reg[g];
        end else if (loadCond(ctl_reg[g].bufferLoadTiming, cnt.mode, matchPulse[g],
                              cnt.maxEvt, cnt.zeroEvt)) begin
          buf_reg[g] <= data_reg[g];
        end
      end
    end

    // output events: A is own match, B is partner match or MAX/ZERO
    assign evtA       = matchPulse[g];
    assign evtB       = ctl_reg[g].pairedMatchSelect ? ((P < NCC) ? matchPulse[P] : 1'b0)
                      : ((cnt.mode == CNT_DOWN) ? cnt.zeroEvt : cnt.maxEvt);
    assign pairedOnly = ctl_reg[g].pairedMatchSelect && evtB;

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        level_reg[g] <= 1'b0;
      end else if (!isCap) begin
        case (ctl_reg[g].outputGenerationMode)
          OUT_SW:      level_reg[g] <= ctl_reg[g].softwareOutputLevel;
          OUT_SET:     level_reg[g] <= level_reg[g] | evtA | pairedOnly;
          OUT_TGL_RST: level_reg[g] <= evtB ? 1'b0 : (level_reg[g] ^ evtA);
          OUT_SET_RST: level_reg[g] <= evtB ? 1'b0 : (level_reg[g] | evtA);
          OUT_TGL:     level_reg[g] <= level_reg[g] ^ (evtA | pairedOnly);
          OUT_RST:     level_reg[g] <= level_reg[g] & ~(evtA | pairedOnly);
          OUT_TGL_SET: level_reg[g] <= evtB ? 1'b1 : (level_reg[g] ^ evtA);
          OUT_RST_SET: level_reg[g] <= evtB ? 1'b1 : (level_reg[g] & ~evtA);
          default:     level_reg[g] <= level_reg[g];
        endcase
      end
    end

    assign outInv[g]     = ctl_reg[g].outputInvert;
    assign flagSet[FLAG_CC_LSB + 2 * g]     = capEvt[g] || matchPulse[g];
    assign flagSet[FLAG_CC_LSB + 2 * g + 1] = capEvt[g] && flags_reg[FLAG_CC_LSB + 2 * g];
  end

  assign waveformOutput = (level_reg ^ outInv) & PRESENT;

  ////////////////////////////////////////////////////////////////////////////
  // flags, enables and interrupt

  assign flagSet[FLAG_MAX_BIT]  = cnt.maxEvt;
  assign flagSet[FLAG_ZERO_BIT] = cnt.zeroEvt;
  assign flagSet[15:14]         = 2'h0;
  assign flagClr    = (regWr && regAddr == OFF_FLAGS) ? regWdata : 16'h0000;
  assign flags_next = ((flags_reg & ~flagClr) | flagSet) & FLAG_MASK;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 16'h0000;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enables_reg <= 16'h0000;
    end else if (regWr && regAddr == OFF_ENABLES) begin
      enables_reg <= regWdata & FLAG_MASK;
    end
  end

  assign irq = |(flags_reg & enables_reg);

  ////////////////////////////////////////////////////////////////////////////
  // counter status and reset request

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_reg <= DIR_RESET;
      run_reg <= RUN_RESET;
    end else begin
      dir_reg <= cnt.up;
      run_reg <= cnt.running;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstReq_reg <= 1'b0;
      rstMax_reg <= 1'b0;
    end else begin
      rstReq_reg <= |mrst;
      rstMax_reg <= (|mrst) && cnt.mode == CNT_DOWN;
    end
  end

  assign counterResetReq   = rstReq_reg;
  assign counterResetToMax = rstMax_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register read

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (regRd) begin
      rdata_reg <= 16'h0000;
      if (regAddr == OFF_STATUS) begin
        rdata_reg[STAT_PIN_LSB +: CC_MAX] <= captureInputPin & PRESENT;
        rdata_reg[STAT_DIR_BIT]           <= dir_reg;
        rdata_reg[STAT_RUN_BIT]           <= run_reg;
      end else if (regAddr == OFF_FLAGS) begin
        rdata_reg <= flags_reg;
      end else if (regAddr == OFF_ENABLES) begin
        rdata_reg <= enables_reg;
      end else if (ctlSlot != SLOT_NONE && PRESENT[ctlSlot[2:0]]) begin
        rdata_reg <= ctl_reg[ctlSlot[2:0]];
      end else if (dataSlot != SLOT_NONE && PRESENT[dataSlot[2:0]]) begin
        rdata_reg <= data_reg[dataSlot[2:0]];
      end
    end
  end

  assign regRdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_irq_gate: assert property (irq == |(flags_reg & enables_reg & FLAG_MASK))
    else $error("irq not equal to gated flags");
  a_w1c_clear: assert property (regWr && regAddr == OFF_FLAGS && regWdata[FLAG_MAX_BIT] && !cnt.maxEvt
    |=> !flags_reg[FLAG_MAX_BIT]) else $error("flag not cleared by write one");
  a_set_wins: assert property (regWr && regAddr == OFF_FLAGS && regWdata[FLAG_ZERO_BIT] && cnt.zeroEvt
    |=> flags_reg[FLAG_ZERO_BIT]) else $error("set lost against clear");
  a_absent_zero: assert property (((flags_reg | enables_reg) & ~FLAG_MASK) == 16'h0000)
    else $error("absent flag or enable bit set");
  a_stat_pins: assert property (regRd && regAddr == OFF_STATUS
    |=> regRdata[STAT_PIN_LSB +: CC_MAX] == $past(captureInputPin & PRESENT)) else $error("pin levels wrong");
  a_buf_immed: assert property (regWr && dataSlot == 4'h0 && !ctl_reg[0].circuitModeSelect
    && ctl_reg[0].bufferLoadTiming == LOAD_IMMED && !capEvt[0]
    |-> ##2 buf_reg[0] == $past(regWdata, 2)) else $error("buffer not loaded after write");
  a_cap_value: assert property (capEvt[0] |=> data_reg[0] == $past(cnt.value))
    else $error("capture value wrong");
  a_cap_ovw: assert property (capEvt[0] && flags_reg[FLAG_CC_LSB] |=> flags_reg[FLAG_CC_LSB + 1])
    else $error("overwrite flag missing");
  a_sw_out: assert property (!ctl_reg[0].circuitModeSelect && ctl_reg[0].outputGenerationMode == OUT_SW
    |=> waveformOutput[0] == ($past(ctl_reg[0].softwareOutputLevel) ^ ctl_reg[0].outputInvert))
    else $error("software output level wrong");
  a_mrst_req: assert property (|mrst |=> counterResetReq
    && counterResetToMax == ($past(cnt.mode) == CNT_DOWN)) else $error("counter reset request wrong");

  c_cap_ovw: cover property (capEvt[0] && flags_reg[FLAG_CC_LSB]);
  c_sw_trig: cover property (gCc[0].swRise && capEvt[0]);
  c_mrst: cover property (counterResetReq);
  c_irq: cover property (irq);

endmodule : ptcc_ctrl

// File: hw/ptcc_pkg.sv
// constants, field layouts and carrier types for the capture/compare control block
package ptcc_pkg;

  localparam int          CC_MAX        = 6;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 16;

  localparam logic [7:0]  OFF_STATUS    = 8'h00;
  localparam logic [7:0]  OFF_FLAGS     = 8'h04;
  localparam logic [7:0]  OFF_ENABLES   = 8'h08;
  localparam logic [7:0]  OFF_CTL_BASE  = 8'h10;
  localparam logic [7:0]  OFF_DATA_BASE = 8'h30;
  localparam logic [3:0]  SLOT_NONE     = 4'hF;

  localparam int          STAT_PIN_LSB  = 2;
  localparam int          STAT_DIR_BIT  = 1;
  localparam int          STAT_RUN_BIT  = 0;
  localparam int          FLAG_CC_LSB   = 2;
  localparam int          FLAG_MAX_BIT  = 1;
  localparam int          FLAG_ZERO_BIT = 0;

  localparam logic        DIR_RESET     = 1'b1;
  localparam logic        RUN_RESET     = 1'b0;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;

  localparam logic [2:0]  LOAD_IMMED    = 3'h0;
  localparam logic [2:0]  LOAD_END      = 3'h1;
  localparam logic [2:0]  LOAD_MATCH    = 3'h2;
  localparam logic [2:0]  LOAD_WRAP     = 3'h3;
  localparam logic [2:0]  LOAD_MRST     = 3'h4;

  localparam logic [1:0]  SRC_PIN       = 2'h0;
  localparam logic [1:0]  SRC_SWLO      = 2'h2;
  localparam logic [1:0]  SRC_SWHI      = 2'h3;

  localparam logic [1:0]  CNT_UP        = 2'h0;
  localparam logic [1:0]  CNT_DOWN      = 2'h1;
  localparam logic [1:0]  CNT_UPDN      = 2'h2;

  localparam logic [2:0]  OUT_SW        = 3'h0;
  localparam logic [2:0]  OUT_SET       = 3'h1;
  localparam logic [2:0]  OUT_TGL_RST   = 3'h2;
  localparam logic [2:0]  OUT_SET_RST   = 3'h3;
  localparam logic [2:0]  OUT_TGL       = 3'h4;
  localparam logic [2:0]  OUT_RST       = 3'h5;
  localparam logic [2:0]  OUT_TGL_SET   = 3'h6;
  localparam logic [2:0]  OUT_RST_SET   = 3'h7;

  typedef struct packed {
    logic       syncCaptureSelect;
    logic [2:0] bufferLoadTiming;
    logic [1:0] captureTriggerSource;
    logic [1:0] captureTriggerEdge;
    logic       reserved;
    logic       pairedMatchSelect;
    logic       softwareOutputLevel;
    logic [2:0] outputGenerationMode;
    logic       outputInvert;
    logic       circuitModeSelect;
  } ptcc_ctl_t;

  typedef struct packed {
    logic [15:0] value;
    logic [1:0]  mode;
    logic        up;
    logic        running;
    logic        maxEvt;
    logic        zeroEvt;
  } ptcc_cnt_t;

endpackage : ptcc_pkg

// File: tb/ptcc_counter_model.sv
// counter core stand-in that feeds the control block its timer state
`timescale 1ns/100ps
module ptcc_counter_model
  import ptcc_pkg::*;
#(
  parameter logic [15:0] MAX_VAL = 16'h001F
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // bench control
  input  wire logic       runCmd,
  input  wire logic [1:0] modeSel,
  // preset requests
  input  wire logic       resetReq,
  input  wire logic       resetToMax,
  // counter state
  output ptcc_cnt_t       cnt
);
  logic [15:0] value_reg;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_reg <= CNT_ZERO;
    end else if (resetReq) begin
      value_reg <= resetToMax ? MAX_VAL : CNT_ZERO;
    end else if (runCmd && modeSel == CNT_DOWN) begin
      value_reg <= (value_reg == CNT_ZERO) ? MAX_VAL : value_reg - 16'h0001;
    end else if (runCmd) begin
      value_reg <= (value_reg >= MAX_VAL) ? CNT_ZERO : value_reg + 16'h0001;
    end
  end
  // events only while counting
  assign cnt = '{value_reg, modeSel, modeSel != CNT_DOWN, runCmd,
                 runCmd && value_reg == MAX_VAL, runCmd && value_reg == CNT_ZERO};
endmodule : ptcc_counter_model

// File: tb/ptcc_ctrl_bench.sv
// self-checking bench for the capture/compare control block
`timescale 1ns/100ps
module ptcc_ctrl_bench
  import ptcc_pkg::*;
;
  localparam logic [5:0]  PIN_MASK  = 6'h0F;
  localparam logic [15:0] FLAG_MASK = 16'h03FF;
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic              regWr;
  logic              regRd;
  logic [DATA_W-1:0] regRdata;
  ptcc_cnt_t         cnt;
  logic              counterResetReq;
  logic              counterResetToMax;
  logic [CC_MAX-1:0] captureInputPin;
  logic [CC_MAX-1:0] waveformOutput;
  logic              irq;
  logic              runCmd;
  logic [1:0]        modeSel;
  logic [31:0]       seedState = 32'h0000636E;
  int                miscompares = 0;
  int                testsRun = 0;
  ////////////////////////////////////////////////////////////
  ptcc_ctrl #(.NCC(4)) uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cnt(cnt), .counterResetReq(counterResetReq),
    .counterResetToMax(counterResetToMax), .captureInputPin(captureInputPin),
    .waveformOutput(waveformOutput), .irq(irq));
  ptcc_counter_model model (.clk(clk), .rst_n(rst_n), .runCmd(runCmd), .modeSel(modeSel),
    .resetReq(counterResetReq), .resetToMax(counterResetToMax), .cnt(cnt));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seedState ^= seedState << 13;
    seedState ^= seedState >> 17;
    seedState ^= seedState << 5;
    return seedState;
  endfunction : rnd
  function automatic logic [15:0] statusExp(input logic [5:0] p, input logic up, input logic run);
    return {8'h00, p & PIN_MASK, up, run};
  endfunction : statusExp
  function automatic logic [15:0] capExp(input logic rise, input logic fall);
    return ((rise | fall) ? 16'h0010 : 16'h0000) | ((rise & fall) ? 16'h0020 : 16'h0000);
  endfunction : capExp
  function automatic logic [7:0] ctlA(input int m);
    return OFF_CTL_BASE + 8'(4 * m);
  endfunction : ctlA
  ////////////////////////////////////////////////////////////
  task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : regWrite
  task automatic regRead(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : regRead
  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkVal
  task automatic checkReg(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] got;
    regRead(a, got);
    checkVal(got, exp);
  endtask : checkReg
  task automatic runTo(input logic [15:0] v);
    @(posedge clk);
    runCmd <= 1'b1;
    for (int i = 0; i < 80 && cnt.value !== v; i++) @(negedge clk);
    @(posedge clk);
    runCmd <= 1'b0;
  endtask : runTo
  task automatic summarize();
    $display("compares %0d miscompares %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  initial begin
    logic [31:0] r;
    logic [15:0] got;
    logic [5:0]  outExp;
    int          k;
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    captureInputPin = 6'h00;
    runCmd = 1'b0;
    modeSel = CNT_UP;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      @(posedge clk);
      captureInputPin <= r[5:0];
      checkReg(OFF_STATUS, statusExp(r[5:0], 1'b1, 1'b0));
    end
    for (int m = 0; m < CC_MAX; m++) begin
      checkReg(ctlA(m), 16'h0000);
      checkReg(OFF_DATA_BASE + 8'(4 * m), 16'h0000);
    end
    checkReg(OFF_FLAGS, 16'h0000);
    checkReg(8'hFC, 16'h0000);
    regWrite(OFF_FLAGS, 16'hFFFF);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      regWrite(OFF_ENABLES, r[15:0]);
      checkReg(OFF_ENABLES, r[15:0] & FLAG_MASK);
    end
    regWrite(OFF_ENABLES, 16'h0000);
    regWrite(ctlA(4), 16'hFFFF);
    checkReg(ctlA(4), 16'h0000);
    @(posedge clk);
    modeSel <= CNT_DOWN;
    runCmd <= 1'b1;
    repeat (3) @(posedge clk);
    checkReg(OFF_STATUS, statusExp(captureInputPin, 1'b0, 1'b1));
    @(posedge clk);
    runCmd <= 1'b0;
    modeSel <= CNT_UP;
    regWrite(OFF_FLAGS, 16'hFFFF);
    @(posedge clk);
    runCmd <= 1'b1;
    repeat (40) @(posedge clk);
    runCmd <= 1'b0;
    checkReg(OFF_FLAGS, 16'h0157);
    regWrite(OFF_FLAGS, 16'h0000);
    checkReg(OFF_FLAGS, 16'h0157);
    checkVal({15'h0000, irq}, 16'h0000);
    regWrite(OFF_ENABLES, 16'h0002);
    #1 checkVal({15'h0000, irq}, 16'h0001);
    regWrite(OFF_FLAGS, 16'h0002);
    checkReg(OFF_FLAGS, 16'h0155);
    checkVal({15'h0000, irq}, 16'h0000);
    regWrite(OFF_FLAGS, 16'hFFFF);
    regWrite(OFF_ENABLES, 16'h0000);
    outExp = 6'h00;
    for (int m = 0; m < 4; m++) begin
      r = rnd();
      outExp[m] = r[0] ^ r[1];
      regWrite(ctlA(m), {10'h000, r[0], 3'h0, r[1], 1'b0});
    end
    @(posedge clk);
    #1 checkVal({10'h000, waveformOutput}, {10'h000, outExp});
    for (int e = 0; e < 4; e++) begin
      regWrite(ctlA(1), 16'h0801 | (16'(e) << 8) | (e[0] ? 16'h8000 : 16'h0000));
      regWrite(OFF_FLAGS, 16'hFFFF);
      regWrite(ctlA(1), 16'h0C01 | (16'(e) << 8) | (e[0] ? 16'h8000 : 16'h0000));
      checkReg(OFF_FLAGS, capExp(e[0], 1'b0));
      regWrite(ctlA(1), 16'h0801 | (16'(e) << 8) | (e[0] ? 16'h8000 : 16'h0000));
      checkReg(OFF_FLAGS, capExp(e[0], e[1]));
    end
    checkReg(OFF_DATA_BASE + 8'h04, cnt.value);
    regWrite(OFF_FLAGS, 16'hFFFF);
    regWrite(ctlA(2), 16'h0900);
    regWrite(ctlA(2), 16'h0D00);
    checkReg(OFF_FLAGS, 16'h0000);
    regWrite(ctlA(2), 16'h0301);
    regWrite(OFF_FLAGS, 16'hFFFF);
    @(posedge clk);
    captureInputPin <= captureInputPin ^ 6'h04;
    checkReg(OFF_FLAGS, 16'h0040);
    @(posedge clk);
    captureInputPin <= captureInputPin ^ 6'h04;
    checkReg(OFF_FLAGS, 16'h00C0);
    regWrite(ctlA(0), 16'h0000);
    regWrite(OFF_DATA_BASE, 16'h0010);
    regWrite(OFF_FLAGS, 16'hFFFF);
    @(posedge clk);
    runCmd <= 1'b1;
    for (k = 0; k < 80 && cnt.value !== 16'h0011; k++) @(negedge clk);
    @(posedge clk);
    runCmd <= 1'b0;
    regRead(OFF_FLAGS, got);
    checkVal(got & 16'h0004, 16'h0004);
    regWrite(ctlA(0), 16'h4000);
    for (int md = 0; md < 2; md++) begin
      @(posedge clk);
      modeSel <= 2'(md);
      runCmd <= 1'b1;
      for (k = 0; k < 80 && counterResetReq !== 1'b1; k++) @(negedge clk);
      checkVal({15'h0000, counterResetReq}, 16'h0001);
      checkVal({15'h0000, counterResetToMax}, {15'h0000, md == 1});
      @(posedge clk);
      runCmd <= 1'b0;
    end
    regWrite(ctlA(0), 16'h1004);
    regWrite(OFF_DATA_BASE, 16'h0005);
    runTo(16'h000C);
    checkVal({15'h0000, waveformOutput[0]}, 16'h0001);
    regWrite(OFF_FLAGS, 16'hFFFF);
    runTo(16'h0003);
    checkReg(OFF_FLAGS, 16'h0000);
    runTo(16'h0004);
    checkReg(OFF_FLAGS, 16'h0107);
    summarize();
  end
endmodule : ptcc_ctrl_bench
